// ---- inc/cgn_pkg.sv ----
`default_nettype none
package cgn_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_PROG     = 8'h04;
  localparam logic [7:0] OFS_STAT     = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // Field positions in the programming register
  localparam int unsigned PROG_N_LSB = 4;
  localparam int unsigned PROG_L_LSB = 0;

  // Interrupt status bit positions
  localparam int unsigned IRQ_LOCK_IN  = 0;
  localparam int unsigned IRQ_LOCK_OUT = 1;

  // Values after reset: crystal source, loop off, automatic bandwidth
  localparam logic [3:0] CTRL_RST = 4'h4;
  localparam logic [7:0] PROG_RST = 8'h11;

  // Nominal centre-of-range frequency in Hz
  localparam logic [31:0] NOM_HZ = 32'h004b_0000;

  // Lock window in reference periods and tolerances in feedback edges
  localparam logic [4:0] LOCK_WIN    = 5'h10;
  localparam logic [5:0] LOCK_WIN_FB = 6'h10;
  localparam logic [5:0] LOCK_TOL    = 6'h01;
  localparam logic [5:0] UNL_TOL     = 6'h02;
  localparam logic [5:0] TRK_TOL     = 6'h02;
  localparam logic [5:0] UNT_TOL     = 6'h04;

  // Edges of each source seen before a source change completes
  localparam logic [1:0] SRC_WAIT = 2'h3;

  // Control register layout, select bit lowest
  typedef struct packed {
    logic track;
    logic auto_bw;
    logic loop_power_on;
    logic base_clock_select;
  } cgn_ctrl_t;

  // Source transition states
  typedef enum logic [0:0] {
    TR_RUN  = 1'b0,
    TR_HOLD = 1'b1
  } cgn_tr_st_t;

  typedef struct packed {
    cgn_tr_st_t st;
    logic       use_osc;
    logic [1:0] xcnt;
    logic [1:0] ocnt;
    logic       base;
  } cgn_tr_t;

  // Whole state of the core
  typedef struct packed {
    cgn_ctrl_t   ctrl;
    logic [3:0]  mul_n;
    logic [3:0]  lin_l;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        aph_vld;
    logic        aph_wr;
    logic [7:0]  aph_addr;
    logic        xtal_q;
    logic        osc_q;
    logic [3:0]  div_cnt;
    logic        fb_pls;
    logic        pfd_up;
    logic        pfd_dn;
    logic [4:0]  win_ref;
    logic [5:0]  win_fb;
    logic        locked;
    logic        tracking;
    logic [31:0] center_hz;
  } cgn_core_t;

  localparam cgn_core_t CORE_RST = '{
    ctrl:    CTRL_RST,
    mul_n:   PROG_RST[PROG_N_LSB +: 4],
    lin_l:   PROG_RST[PROG_L_LSB +: 4],
    default: '0
  };

  localparam cgn_tr_t TR_RST = '{st: TR_RUN, default: '0};

endpackage
`default_nettype wire

// ---- logic/cgn_trans.sv ----
`timescale 1ns/1ps
`default_nettype none
module cgn_trans
  import cgn_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Source edges and request
  input  wire logic xtal_rise_i,
  input  wire logic osc_rise_i,
  input  wire logic want_osc_i,
  // Selected source and halved output
  output logic      use_osc_o,
  output logic      hold_o,
  output logic      base_o
);

  cgn_tr_t r_ff;
  cgn_tr_t nxt_r;

  // Counts edges but never past the wait figure
  function automatic logic [1:0] sat_inc(input logic [1:0] c, input logic e);
    sat_inc = (e && c != SRC_WAIT) ? c + 2'h1 : c;
  endfunction

  always_comb begin
    nxt_r = r_ff;
    case (r_ff.st)
      TR_RUN: begin
        // Halve the selected source to even out the duty cycle
        if (r_ff.use_osc ? osc_rise_i : xtal_rise_i) begin
          nxt_r.base = ~r_ff.base;
        end
        if (want_osc_i != r_ff.use_osc) begin
          nxt_r.st   = TR_HOLD;
          nxt_r.xcnt = 2'h0;
          nxt_r.ocnt = 2'h0;
        end
      end
      TR_HOLD: begin
        nxt_r.xcnt = sat_inc(r_ff.xcnt, xtal_rise_i);
        nxt_r.ocnt = sat_inc(r_ff.ocnt, osc_rise_i);
        // A request withdrawn mid-wait returns at once
        if (want_osc_i == r_ff.use_osc) begin
          nxt_r.st = TR_RUN;
        end else if (nxt_r.xcnt == SRC_WAIT && nxt_r.ocnt == SRC_WAIT) begin
          nxt_r.st      = TR_RUN;
          nxt_r.use_osc = want_osc_i;
        end
      end
      default: nxt_r = TR_RST;
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_ff <= TR_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign use_osc_o = r_ff.use_osc;
  assign hold_o    = (r_ff.st == TR_HOLD);
  assign base_o    = r_ff.base;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_hold;
    r_ff.st == TR_HOLD;
  endsequence

  base_static_a: assert property (s_hold |=> $stable(base_o))
    else $error("base clock moved during a source change");
  switch_held_a: assert property (
    $changed(use_osc_o) |-> $past(r_ff.st) == TR_HOLD
      && $past(r_ff.xcnt) != 2'h0 && $past(r_ff.ocnt) != 2'h0)
    else $error("source changed without a hold");

endmodule
`default_nettype wire

// ---- logic/cgn_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module cgn_top
  import cgn_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  // AHB-Lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  // Clock sources, sampled
  input  wire logic        CRYSTAL_IN_I,
  input  wire logic        OSCILLATOR_CLOCK_I,
  input  wire logic        OSCILLATOR_ENABLE_I,
  // Generated clocks
  output logic             CRYSTAL_CLOCK_O,
  output logic             LOOP_REFERENCE_CLOCK_O,
  output logic             FINAL_REFERENCE_CLOCK_O,
  output logic             FEEDBACK_CLOCK_O,
  output logic             BASE_CLOCK_OUT_O,
  // Loop control towards the analog side
  output logic             LOOP_POWER_ON_O,
  output logic             PUMP_UP_O,
  output logic             PUMP_DN_O,
  output logic             FILTER_FAST_O,
  output logic      [31:0] CENTER_HZ_O,
  // Status and interrupt
  output logic             LOCK_O,
  output logic             CLOCK_UNIT_INTERRUPT_O
);

  cgn_core_t r_ff;
  cgn_core_t nxt_r;

  logic       xq;
  logic       xtal_rise;
  logic       osc_rise;
  logic       fb_rise;
  logic       loop_eff;
  logic       wr_ctrl;
  logic [5:0] fb_total;
  logic [5:0] dev;
  logic [1:0] lock_evt;
  logic [1:0] irq_clr;
  logic       use_osc;
  logic       hold;
  logic       base;
  cgn_ctrl_t  wctrl;

  // Effective multiplier, zero reads as one
  function automatic logic [3:0] n_eff(input logic [3:0] n);
    n_eff = (n == 4'h0) ? 4'h1 : n;
  endfunction

  // Distance between two edge counts
  function automatic logic [5:0] absdiff(input logic [5:0] a,
                                         input logic [5:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  always_comb begin
    nxt_r     = r_ff;
    wctrl     = cgn_ctrl_t'(HWDATA_I[3:0]);
    wr_ctrl   = r_ff.aph_vld & r_ff.aph_wr & (r_ff.aph_addr == OFS_CTRL);
    irq_clr   = 2'h0;
    lock_evt  = 2'h0;
    dev       = 6'h0;

    // crystal edges count only while enabled
    xq        = CRYSTAL_IN_I & OSCILLATOR_ENABLE_I;
    xtal_rise = xq & ~r_ff.xtal_q;
    osc_rise  = OSCILLATOR_CLOCK_I & ~r_ff.osc_q;
    nxt_r.xtal_q = xq;
    nxt_r.osc_q  = OSCILLATOR_CLOCK_I;

    // zero linear factor disables the loop
    loop_eff = r_ff.ctrl.loop_power_on & (r_ff.lin_l != 4'h0);

    fb_rise = loop_eff & osc_rise & (r_ff.div_cnt == 4'h0);
    if (!loop_eff) begin
      nxt_r.div_cnt = 4'h0;
    end else if (osc_rise) begin
      nxt_r.div_cnt = (r_ff.div_cnt >= n_eff(r_ff.mul_n) - 4'h1) ?
                      4'h0 : r_ff.div_cnt + 4'h1;
    end
    nxt_r.fb_pls = fb_rise;

    // phase detector, both raised cancel each other
    nxt_r.pfd_up = loop_eff & (r_ff.pfd_up | xtal_rise);
    nxt_r.pfd_dn = loop_eff & (r_ff.pfd_dn | fb_rise);
    if (nxt_r.pfd_up & nxt_r.pfd_dn) begin
      nxt_r.pfd_up = 1'b0;
      nxt_r.pfd_dn = 1'b0;
    end

    // Feedback edges seen in the current window, saturating
    fb_total = (fb_rise && r_ff.win_fb != 6'h3f) ?
               r_ff.win_fb + 6'h01 : r_ff.win_fb;

    if (!loop_eff) begin
      nxt_r.win_ref  = 5'h0;
      nxt_r.win_fb   = 6'h0;
      nxt_r.locked   = 1'b0;
      nxt_r.tracking = 1'b0;
    end else if (xtal_rise && r_ff.win_ref == LOCK_WIN - 5'h1) begin
      dev           = absdiff(fb_total, LOCK_WIN_FB);
      nxt_r.win_ref = 5'h0;
      nxt_r.win_fb  = 6'h0;
      // Hysteresis keeps lock from chattering near the edge
      if (dev <= LOCK_TOL) begin
        nxt_r.locked = 1'b1;
      end else if (dev > UNL_TOL) begin
        nxt_r.locked = 1'b0;
      end
      if (dev <= TRK_TOL) begin
        nxt_r.tracking = 1'b1;
      end else if (dev > UNT_TOL) begin
        nxt_r.tracking = 1'b0;
      end
    end else begin
      nxt_r.win_ref = xtal_rise ? r_ff.win_ref + 5'h1 : r_ff.win_ref;
      nxt_r.win_fb  = fb_total;
    end

    // manual mode takes the mode bit from software
    if (!r_ff.ctrl.auto_bw) begin
      nxt_r.tracking = loop_eff & r_ff.ctrl.track;
      nxt_r.locked   = 1'b0;
    end

    lock_evt[IRQ_LOCK_IN]  = nxt_r.locked & ~r_ff.locked;
    lock_evt[IRQ_LOCK_OUT] = ~nxt_r.locked & r_ff.locked;

    // centre frequency from the linear factor
    nxt_r.center_hz = 32'(r_ff.lin_l) * NOM_HZ;

    // Address phase capture; every transfer finishes at once
    nxt_r.aph_vld  = HSEL_I & HREADY_I & HTRANS_I[1];
    nxt_r.aph_wr   = HWRITE_I;
    nxt_r.aph_addr = HADDR_I[7:0];

    // Data phase writes
    if (r_ff.aph_vld & r_ff.aph_wr) begin
      case (r_ff.aph_addr)
        OFS_CTRL: begin
          nxt_r.ctrl.auto_bw = wctrl.auto_bw;
          // Mode bit is read-only while bandwidth is automatic
          if (!r_ff.ctrl.auto_bw) begin
            nxt_r.ctrl.track = wctrl.track;
          end
          // select only with loop on, power off only deselected
          if (!wctrl.base_clock_select || loop_eff) begin
            nxt_r.ctrl.base_clock_select = wctrl.base_clock_select;
          end
          if (wctrl.loop_power_on || !r_ff.ctrl.base_clock_select) begin
            nxt_r.ctrl.loop_power_on = wctrl.loop_power_on;
          end
        end
        OFS_PROG: begin
          nxt_r.mul_n = HWDATA_I[PROG_N_LSB +: 4];
          nxt_r.lin_l = HWDATA_I[PROG_L_LSB +: 4];
        end
        OFS_IRQ_STAT: irq_clr = HWDATA_I[1:0];
        OFS_IRQ_MASK: nxt_r.irq_mask = HWDATA_I[1:0];
        default: ;
      endcase
    end

    // zero linear factor forces the crystal source
    if (nxt_r.lin_l == 4'h0) begin
      nxt_r.ctrl.base_clock_select = 1'b0;
    end

    // sticky flags, a new event beats a same-cycle clear
    nxt_r.irq_stat = (r_ff.irq_stat & ~irq_clr) | lock_evt;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      r_ff <= CORE_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Read mux over registered state; unmapped offsets read zero
  always_comb begin
    HRDATA_O = 32'h0000_0000;
    if (r_ff.aph_vld & ~r_ff.aph_wr) begin
      case (r_ff.aph_addr)
        OFS_CTRL:     HRDATA_O = {28'h0, r_ff.ctrl};
        OFS_PROG:     HRDATA_O = {24'h0, r_ff.mul_n, r_ff.lin_l};
        OFS_STAT:     HRDATA_O = {27'h0, loop_eff, r_ff.tracking,
                                  r_ff.locked, hold, use_osc};
        OFS_IRQ_STAT: HRDATA_O = {30'h0, r_ff.irq_stat};
        OFS_IRQ_MASK: HRDATA_O = {30'h0, r_ff.irq_mask};
        default:      HRDATA_O = 32'h0000_0000;
      endcase
    end
  end

  cgn_trans u_trans (
    .clk_i       (CLK_I),
    .rst_n_i     (RST_N_I),
    .xtal_rise_i (xtal_rise),
    .osc_rise_i  (osc_rise),
    .want_osc_i  (r_ff.ctrl.base_clock_select),
    .use_osc_o   (use_osc),
    .hold_o      (hold),
    .base_o      (base)
  );

  // Bus answers: no wait states, always OKAY
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

  // crystal and loop reference share one buffered flop
  assign CRYSTAL_CLOCK_O        = r_ff.xtal_q;
  assign LOOP_REFERENCE_CLOCK_O = r_ff.xtal_q;
  // final reference is the same level
  assign FINAL_REFERENCE_CLOCK_O = r_ff.xtal_q;
  assign FEEDBACK_CLOCK_O        = r_ff.fb_pls;
  assign BASE_CLOCK_OUT_O        = base;
  assign LOOP_POWER_ON_O         = loop_eff;
  assign PUMP_UP_O               = r_ff.pfd_up;
  assign PUMP_DN_O               = r_ff.pfd_dn;
  assign FILTER_FAST_O           = loop_eff & ~r_ff.tracking;
  assign CENTER_HZ_O             = r_ff.center_hz;
  assign LOCK_O                  = r_ff.locked;
  assign CLOCK_UNIT_INTERRUPT_O  = |(r_ff.irq_stat & r_ff.irq_mask);

  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_sel_refused;
    wr_ctrl && HWDATA_I[0] && !loop_eff && !r_ff.ctrl.base_clock_select;
  endsequence

  sequence s_off_refused;
    wr_ctrl && !HWDATA_I[1] && r_ff.ctrl.base_clock_select;
  endsequence

  sel_refuse_a: assert property (s_sel_refused |=>
      !r_ff.ctrl.base_clock_select)
    else $error("oscillator selected with loop off");
  off_refuse_a: assert property (s_off_refused |=>
      r_ff.ctrl.loop_power_on)
    else $error("loop turned off while selected");
  l_zero_a: assert property (r_ff.lin_l == 4'h0 |->
      !r_ff.ctrl.base_clock_select && !LOOP_POWER_ON_O)
    else $error("zero linear factor left loop usable");
  div_one_a: assert property (loop_eff && r_ff.mul_n <= 4'h1
      && osc_rise |=> r_ff.div_cnt == 4'h0)
    else $error("divide by one did not hold count at zero");
  fb_rate_a: assert property (FEEDBACK_CLOCK_O |->
      $past(r_ff.div_cnt) == 4'h0 && $past(osc_rise))
    else $error("feedback pulse without divider wrap");
  pfd_excl_a: assert property (!(PUMP_UP_O && PUMP_DN_O))
    else $error("pump up and down together");
  lock_pace_a: assert property ($changed(LOCK_O) && loop_eff
      && r_ff.ctrl.auto_bw |-> $past(xtal_rise))
    else $error("lock moved off a reference edge");
  manual_lock_a: assert property (!r_ff.ctrl.auto_bw |=>
      !LOCK_O
      && r_ff.tracking == ($past(loop_eff) && $past(r_ff.ctrl.track)))
    else $error("manual mode lock or mode wrong");
  fast_mode_a: assert property (loop_eff |->
      FILTER_FAST_O == !r_ff.tracking)
    else $error("filter speed disagrees with mode");
  center_a: assert property ($stable(r_ff.lin_l) && $past(RST_N_I) |->
      CENTER_HZ_O == 32'(r_ff.lin_l) * NOM_HZ)
    else $error("centre frequency wrong");
  lock_irq_a: assert property (lock_evt[IRQ_LOCK_IN] |=>
      r_ff.irq_stat[IRQ_LOCK_IN])
    else $error("lock entry event lost");
  unlock_irq_a: assert property (lock_evt[IRQ_LOCK_OUT] |=>
      r_ff.irq_stat[IRQ_LOCK_OUT])
    else $error("lock exit event lost");

endmodule
`default_nettype wire

// ---- test/cgn_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cgn_src_model #(
  parameter int XTAL_HALF_NS = 160
) (
  // Enables from the system side and the loop
  input  wire logic osc_en_i,
  input  wire logic vco_on_i,
  // Oscillator half period, set by the bench
  input  var  int   vco_half_ns_i,
  // Clock outputs
  output logic      xtal_o,
  output logic      vco_o
);
  // Both start low so the first seen edge is a clean rise
  initial begin
    xtal_o = 1'b0;
    vco_o  = 1'b0;
  end
  always begin
    #(XTAL_HALF_NS);
    xtal_o = osc_en_i ? ~xtal_o : 1'b0;
  end
  // Analog loop stand-in; a floor on the delay avoids a zero-time spin
  always begin
    #(vco_half_ns_i > 20 ? vco_half_ns_i : 20);
    vco_o = vco_on_i ? ~vco_o : 1'b0;
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cgn_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        osc_en = 1'b1;
  int          vco_half = 80;
  integer      seed = 32'h44d6;
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic        dph = 1'b0;
  logic [31:0] rexp_q[$];
  logic [31:0] pexp_q[$];
  logic [31:0] pgot_q[$];
  logic [6:0]  prv = 7'h0;
  int          cnt[7];
  int          d[7];
  wire         xtal;
  wire         vco;
  wire         hready;
  wire         hresp;
  wire  [31:0] hrdata;
  wire         lock, irq, fast, pwr, xclk, rclk, fclk, fb, base, up, dn;
  wire  [31:0] center;

  // Clock at 25 MHz
  always #20 clk = ~clk;

  cgn_top dut (
    .CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .CRYSTAL_IN_I(xtal),
    .OSCILLATOR_CLOCK_I(vco), .OSCILLATOR_ENABLE_I(osc_en),
    .CRYSTAL_CLOCK_O(xclk), .LOOP_REFERENCE_CLOCK_O(rclk),
    .FINAL_REFERENCE_CLOCK_O(fclk), .FEEDBACK_CLOCK_O(fb),
    .BASE_CLOCK_OUT_O(base), .LOOP_POWER_ON_O(pwr), .PUMP_UP_O(up),
    .PUMP_DN_O(dn), .FILTER_FAST_O(fast), .CENTER_HZ_O(center),
    .LOCK_O(lock), .CLOCK_UNIT_INTERRUPT_O(irq)
  );

  cgn_src_model model (
    .osc_en_i(osc_en), .vco_on_i(pwr), .vco_half_ns_i(vco_half),
    .xtal_o(xtal), .vco_o(vco)
  );

  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t expected %h got %h", $time, e, g);
    end
  endtask

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Monitor: read data in its data phase, pin notes one edge later
  always @(posedge clk) begin
    if (dph) cmp(rexp_q.pop_front(), hrdata);
    while (pgot_q.size() > 0) cmp(pexp_q.pop_front(), pgot_q.pop_front());
    dph <= hsel && hready && htrans[1] && !hwrite;
  end

  // Rising edges of the clock-like outputs, free running
  always @(posedge clk) begin
    for (int i = 0; i < 7; i++) begin
      if (cnt_in()[i] && !prv[i]) cnt[i]++;
    end
    prv <= cnt_in();
  end

  function automatic logic [6:0] cnt_in();
    return {up | dn, base, fb, vco, fclk, rclk, xclk};
  endfunction

  // Hang guard, well above the roughly 4300 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 15000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One single transfer; both phases held until ready is seen
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= v;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(a, 1'b1, v);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rexp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    pexp_q.push_back(e);
    pgot_q.push_back(g);
  endtask

  // Edge counts over a window of n cycles
  task automatic win(input int n);
    int s[7];
    s = cnt;
    tick(n);
    for (int i = 0; i < 7; i++) d[i] = cnt[i] - s[i];
  endtask

  function automatic logic [31:0] near(input int a, input int b);
    return (a - b <= 1 && b - a <= 1) ? 32'h1 : 32'h0;
  endfunction

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  initial begin
    logic [3:0] l;
    logic [3:0] n;
    tick(6);
    rst_n <= 1'b1;
    tick(1);
    rd(OFS_CTRL, {28'h0, CTRL_RST});
    rd(OFS_PROG, {24'h0, PROG_RST});
    rd(OFS_STAT, 32'h0);
    rd(OFS_IRQ_STAT, 32'h0);
    rd(OFS_IRQ_MASK, 32'h0);
    rd(8'h14, 32'h0);
    chk(32'h0, {31'h0, lock});
    chk(32'h0, {31'h0, hresp});
    wr(OFS_CTRL, 32'h5);
    rd(OFS_CTRL, 32'h4);
    done("reset");
    // Centre frequency for random factors, top value last
    for (int k = 0; k < 4; k++) begin
      l = 4'(({$random(seed)} % 15) + 1);
      n = 4'($random(seed));
      if (k == 3) l = 4'hf;
      wr(OFS_PROG, {24'h0, n, l});
      rd(OFS_PROG, {24'h0, n, l});
      tick(2);
      chk(32'(l) * 32'h004b_0000, center);
    end
    wr(OFS_PROG, 32'h20);
    wr(OFS_CTRL, 32'h6);
    tick(1);
    chk(32'h0, {31'h0, pwr});
    rd(OFS_STAT, 32'h0);
    wr(OFS_CTRL, 32'h7);
    rd(OFS_CTRL, 32'h6);
    done("program");
    // Lock with N of two and matching oscillator
    wr(OFS_IRQ_MASK, 32'h3);
    wr(OFS_PROG, 32'h21);
    tick(800);
    chk(32'h1, {31'h0, lock});
    rd(OFS_STAT, 32'h1c);
    chk(32'h0, {31'h0, fast});
    rd(OFS_IRQ_STAT, 32'h1);
    chk(32'h1, {31'h0, irq});
    wr(OFS_IRQ_STAT, 32'h1);
    tick(1);
    chk(32'h0, {31'h0, irq});
    win(640);
    chk(32'h1, near(d[0], 80));
    chk(d[0], d[1]);
    chk(d[0], d[2]);
    chk(32'h1, near(d[4], d[3] / 2));
    chk(32'h1, near(d[5], d[0] / 2));
    done("lock");
    // Oscillator as base source, then a refused power-off
    wr(OFS_CTRL, 32'h7);
    tick(60);
    rd(OFS_STAT, 32'h1d);
    win(640);
    chk(32'h1, near(d[5], d[3] / 2));
    wr(OFS_CTRL, 32'h5);
    rd(OFS_CTRL, 32'h7);
    done("select");
    // Oscillator drifts far off, lock is lost
    vco_half <= 120;
    tick(800);
    chk(32'h0, {31'h0, lock});
    rd(OFS_IRQ_STAT, 32'h2);
    chk(32'h1, {31'h0, fast});
    wr(OFS_IRQ_STAT, 32'h2);
    // Rates differ here, so the pump must fire
    win(200);
    chk(32'h1, {31'h0, d[6] > 0});
    done("unlock");
    // N of zero divides by one
    wr(OFS_CTRL, 32'h6);
    tick(60);
    wr(OFS_PROG, 32'h01);
    vco_half <= 160;
    tick(800);
    chk(32'h1, {31'h0, lock});
    done("zero_n");
    // Manual bandwidth mode
    // Track bit only takes once automatic mode is already off
    wr(OFS_CTRL, 32'ha);
    wr(OFS_CTRL, 32'ha);
    tick(2);
    rd(OFS_STAT, 32'h18);
    chk(32'h0, {31'h0, lock});
    wr(OFS_CTRL, 32'h2);
    tick(2);
    rd(OFS_STAT, 32'h10);
    chk(32'h1, {31'h0, fast});
    done("manual");
    // Crystal disabled by the system side
    osc_en <= 1'b0;
    tick(20);
    win(200);
    chk(32'h0, d[0]);
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    rd(OFS_CTRL, 32'h4);
    chk(32'h0, {31'h0, lock});
    done("rerun");
    tick(3);
    conclude();
  end
endmodule
`default_nettype wire
